/* File: dv/cmd_dec_chk.sv */
// port assertions for the channel command decoder
`timescale 1ns/1ps
module cmd_dec_chk (
    input wire logic                         i_mclk,            // clock
    input wire logic                         i_nrst,            // reset
    input wire logic                         i_wr,              // write
    input wire logic [3:0]                   i_addr,            // offset
    input wire logic [7:0]                   i_wdata,           // data
    input wire logic                         i_tx_idle,         // tx idle
    input wire logic                         i_multidrop,       // multi-drop
    input wire logic                         i_wakeup_mode,     // wake-up
    input wire logic                         o_rx_enabled,      // rx state
    input wire logic                         o_rx_active,       // rx live
    input wire logic                         o_tx_enabled,      // tx state
    input wire logic                         o_tx_running,      // tx live
    input wire logic                         o_tx_space_flag,   // ready
    input wire logic                         o_tx_drained_flag, // empty
    input wire cmd_decoder_pkg::dir_pulse_t  o_dir,             // dir pulses
    input wire cmd_decoder_pkg::misc_pulse_t o_misc,            // misc pulses
    input wire logic                         o_misc_busy        // gap flag
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_nrst);
    wire       cmd = i_wr && i_addr == 4'h2;
    wire [3:0] code = i_wdata[7:4];
    function automatic logic [4:0] misc_of(input logic [3:0] c);
        return {c == 4'h1, c == 4'h2, c == 4'h3, c == 4'h4, c == 4'h5};
    endfunction
    tx_off_a: assert property (
        cmd && i_wdata[3] |=> !o_tx_enabled && !o_tx_space_flag
        && !o_tx_drained_flag) else $error("tx off");
    tx_on_a: assert property (
        cmd && i_wdata[3:2] == 2'b01 && code != 4'h3 |=> o_tx_enabled)
        else $error("tx not enabled");
    flag_rise_a: assert property (
        !cmd && o_tx_enabled && i_tx_idle
        |=> o_tx_space_flag && o_tx_drained_flag) else $error("tx flags low");
    rx_off_a: assert property (
        cmd && (i_wdata[1] || code == 4'h2) |=> !o_rx_enabled)
        else $error("rx not disabled");
    rx_on_a: assert property (
        cmd && i_wdata[1:0] == 2'b01 && code != 4'h2
        |=> o_rx_enabled && o_dir.rx_search != $past(i_wakeup_mode))
        else $error("rx enable wrong");
    rx_live_a: assert property (
        o_rx_active == (o_rx_enabled || i_multidrop))
        else $error("rx active wrong");
    tx_run_a: assert property (
        o_tx_running == (o_tx_enabled || !i_tx_idle))
        else $error("tx running wrong");
    misc_map_a: assert property (
        cmd |=> o_misc == misc_of($past(code)))
        else $error("misc decode wrong");
    misc_quiet_a: assert property (
        !cmd |=> o_misc == 5'h0 && o_dir == 5'h0)
        else $error("stray pulse");
    busy_gap_a: assert property (
        cmd && code != 4'h0 |=> o_misc_busy [*3])
        else $error("gap flag short");
    cover property (cmd && i_wdata == 8'h25);
    cover property (cmd && i_wdata[3:0] == 4'hf);
    cover property (o_tx_space_flag && o_rx_enabled);
endmodule

/* File: dv/host_model.sv */
// host processor model writing the command register
`timescale 1ns/1ps
module host_model (
    input  wire logic       i_mclk,  // bus clock
    output logic            o_wr,    // write strobe
    output logic [3:0]      o_addr,  // offset
    output logic [7:0]      o_wdata  // data
);
    initial begin
        o_wr = 1'b0;
        o_addr = 4'h0;
        o_wdata = 8'h00;
    end
    task automatic write(input logic [3:0] a, input logic [7:0] d);
        repeat (3) @(posedge i_mclk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
    endtask
endmodule

/* File: dv/testbench.sv */
// self-checking bench for the channel command decoder
`timescale 1ns/1ps
module testbench;
    logic i_mclk, i_nrst, i_wr, i_tx_idle, i_multidrop, i_wakeup_mode;
    logic [3:0] i_addr;
    logic [7:0] i_wdata;
    logic o_rx_enabled, o_rx_active, o_tx_enabled, o_tx_running;
    logic o_tx_space_flag, o_tx_drained_flag, o_misc_busy;
    cmd_decoder_pkg::dir_pulse_t  o_dir;
    cmd_decoder_pkg::misc_pulse_t o_misc;
    int   n_mismatch = 0;
    int   checks_done = 0;
    logic rx_e = 1'b0;
    logic tx_e = 1'b0;
    logic [7:0] corner [8] = '{8'h25, 8'h0f, 8'h11, 8'h35, 8'h40, 8'h5a,
                               8'h00, 8'h6c};
    uart_channel_command_decoder uart_channel_command_decoder_inst (.*);
    host_model host_model_inst (.i_mclk(i_mclk), .o_wr(i_wr),
                                .o_addr(i_addr), .o_wdata(i_wdata));
    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
        end
    endtask
    function automatic logic [4:0] exp_misc(input logic [3:0] c);
        return {c == 4'h1, c == 4'h2, c == 4'h3, c == 4'h4, c == 4'h5};
    endfunction
    function automatic logic [4:0] exp_dir(input logic [7:0] d,
                                           input logic       wake);
        return {d[0] & !d[1], d[1], d[0] & !d[1] & !wake,
                d[2] & !d[3], d[3]};
    endfunction
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic step(input logic [3:0] a, input logic [7:0] d);
        logic cmd;
        cmd = (a == cmd_decoder_pkg::COMMAND_REG_CHAN_A_OFFSET);
        @(posedge i_mclk);
        i_tx_idle <= 1'($urandom);
        i_multidrop <= 1'($urandom);
        i_wakeup_mode <= 1'($urandom);
        host_model_inst.write(a, d);
        #1;
        if (cmd) begin
            rx_e = (d[1] || d[7:4] == 4'h2) ? 1'b0 : (d[0] ? 1'b1 : rx_e);
            tx_e = (d[3] || d[7:4] == 4'h3) ? 1'b0 : (d[2] ? 1'b1 : tx_e);
        end
        check(o_rx_enabled, rx_e);
        check(o_tx_enabled, tx_e);
        check(o_misc, cmd ? exp_misc(d[7:4]) : 5'h0);
        check(o_dir, cmd ? exp_dir(d, i_wakeup_mode) : 5'h0);
        check(o_rx_active, rx_e | i_multidrop);
        check(o_tx_running, tx_e | !i_tx_idle);
        check(o_misc_busy, cmd && d[7:4] != 4'h0);
        @(posedge i_mclk);
        #1;
        if (!tx_e || i_tx_idle)
            check({o_tx_space_flag, o_tx_drained_flag}, {2{tx_e}});
    endtask
    initial begin
        i_nrst = 1'b0;
        i_tx_idle = 1'b1;
        i_multidrop = 1'b0;
        i_wakeup_mode = 1'b0;
        void'($urandom(32'h2d9e1fbe));
        repeat (6) @(posedge i_mclk);
        i_nrst <= 1'b1;
        foreach (corner[k]) step(4'h2, corner[k]);
        repeat (300) step($urandom_range(1) ? 4'h2 : 4'($urandom),
                          8'($urandom));
        results();
    end
endmodule
bind uart_channel_command_decoder cmd_dec_chk cmd_dec_chk_inst (.*);

/* File: src/cmd_decoder_pkg.sv */
// shared constants and types for the channel command decoder
package cmd_decoder_pkg;
    localparam logic [3:0] COMMAND_REG_CHAN_A_OFFSET = 4'h2;
    localparam int         RX_ENABLE_BIT    = 0;
    localparam int         RX_DISABLE_BIT   = 1;
    localparam int         TX_ENABLE_BIT    = 2;
    localparam int         TX_DISABLE_BIT   = 3;
    localparam int         MISC_LSB         = 4;
    localparam logic [3:0] MISC_NONE        = 4'h0;
    localparam logic [3:0] MISC_MR_PTR      = 4'h1;
    localparam logic [3:0] MISC_RX_RESET    = 4'h2;
    localparam logic [3:0] MISC_TX_RESET    = 4'h3;
    localparam logic [3:0] MISC_ERR_RESET   = 4'h4;
    localparam logic [3:0] MISC_BRK_CLEAR   = 4'h5;
    localparam logic [1:0] MISC_GAP_EDGES   = 2'h3;
    localparam logic       RX_EN_RESET      = 1'b0;
    localparam logic       TX_EN_RESET      = 1'b0;

    typedef struct packed {
        logic mr_ptr_reset;
        logic rx_reset;
        logic tx_reset;
        logic err_clear;
        logic brk_clear;
    } misc_pulse_t;

    typedef struct packed {
        logic rx_enable;
        logic rx_disable;
        logic rx_search;
        logic tx_enable;
        logic tx_disable;
    } dir_pulse_t;
endpackage

/* File: src/misc_cmd_decode.sv */
// decoder for the upper-nibble miscellaneous command codes
`timescale 1ns/1ps
module misc_cmd_decode (
    input  wire logic                         i_strobe, // write to command reg
    input  wire logic [3:0]                   i_code,   // upper nibble
    output cmd_decoder_pkg::misc_pulse_t      o_pulse   // decoded actions
);
    always_comb begin
        o_pulse = '0;
        if (i_strobe) begin
            unique case (i_code)
                cmd_decoder_pkg::MISC_MR_PTR:    o_pulse.mr_ptr_reset = 1'b1;
                cmd_decoder_pkg::MISC_RX_RESET:  o_pulse.rx_reset = 1'b1;
                cmd_decoder_pkg::MISC_TX_RESET:  o_pulse.tx_reset = 1'b1;
                cmd_decoder_pkg::MISC_ERR_RESET: o_pulse.err_clear = 1'b1;
                cmd_decoder_pkg::MISC_BRK_CLEAR: o_pulse.brk_clear = 1'b1;
                default:                         o_pulse = '0;
            endcase
        end
    end
endmodule

/* File: src/uart_channel_command_decoder.sv */
// command register decoder for one uart channel
`timescale 1ns/1ps
module uart_channel_command_decoder (
    input  wire logic                       i_mclk,        // 10 mhz clock
    input  wire logic                       i_nrst,        // async reset, low
    input  wire logic                       i_wr,          // register write
    input  wire logic [3:0]                 i_addr,        // register offset
    input  wire logic [7:0]                 i_wdata,       // write data
    input  wire logic                       i_tx_idle,     // tx shifter+fifo empty
    input  wire logic                       i_multidrop,   // special multi-drop
    input  wire logic                       i_wakeup_mode, // special wake-up
    output logic                            o_rx_enabled,  // rx enable state
    output logic                            o_rx_active,   // rx may operate
    output logic                            o_tx_enabled,  // tx enable state
    output logic                            o_tx_running,  // tx enabled or still sending
    output logic                            o_tx_space_flag,   // tx ready flag
    output logic                            o_tx_drained_flag, // tx empty flag
    output cmd_decoder_pkg::dir_pulse_t     o_dir,         // direction pulses
    output cmd_decoder_pkg::misc_pulse_t    o_misc,        // misc pulses
    output logic                            o_misc_busy    // gap not elapsed
);
    logic                         strobe;
    logic [3:0]                   code;
    logic                         misc_cmd;
    logic                         rx_on;
    logic                         rx_off;
    logic                         tx_on;
    logic                         tx_off;
    cmd_decoder_pkg::misc_pulse_t misc_dec;
    cmd_decoder_pkg::misc_pulse_t misc;

    // receiver group
    logic                         rx_en;
    logic                         rx_enable;
    logic                         rx_disable;
    logic                         rx_search;
    logic                         next_rx_en;
    logic                         next_rx_enable;
    logic                         next_rx_disable;
    logic                         next_rx_search;

    // transmitter group
    logic                         tx_en;
    logic                         tx_enable;
    logic                         tx_disable;
    logic                         space_flag;
    logic                         drained_flag;
    logic                         next_tx_en;
    logic                         next_tx_enable;
    logic                         next_tx_disable;
    logic                         next_space_flag;
    logic                         next_drained_flag;

    // spacing window group
    logic [1:0]                   gap;
    logic [1:0]                   next_gap;

    assign strobe   = i_wr && (i_addr ==
                      cmd_decoder_pkg::COMMAND_REG_CHAN_A_OFFSET);
    assign code     = i_wdata[7:cmd_decoder_pkg::MISC_LSB];
    assign misc_cmd = strobe && (code != cmd_decoder_pkg::MISC_NONE);

    misc_cmd_decode misc_cmd_decode_inst (
        .i_strobe (strobe),
        .i_code   (code),
        .o_pulse  (misc_dec)
    );

    always_comb begin
        rx_on  = strobe && i_wdata[cmd_decoder_pkg::RX_ENABLE_BIT];
        rx_off = strobe && i_wdata[cmd_decoder_pkg::RX_DISABLE_BIT];
        tx_on  = strobe && i_wdata[cmd_decoder_pkg::TX_ENABLE_BIT];
        tx_off = strobe && i_wdata[cmd_decoder_pkg::TX_DISABLE_BIT];
    end

    // receiver state and pulses
    always_comb begin
        next_rx_en      = rx_en;
        next_rx_enable  = 1'b0;
        next_rx_disable = 1'b0;
        next_rx_search  = 1'b0;
        if (rx_off) begin
            next_rx_en      = 1'b0;
            next_rx_disable = 1'b1;
        end else if (rx_on) begin
            next_rx_en     = 1'b1;
            next_rx_enable = 1'b1;
            next_rx_search = !i_wakeup_mode;
        end
        if (misc_dec.rx_reset) begin
            next_rx_en = cmd_decoder_pkg::RX_EN_RESET;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            rx_en      <= cmd_decoder_pkg::RX_EN_RESET;
            rx_enable  <= 1'b0;
            rx_disable <= 1'b0;
            rx_search  <= 1'b0;
        end else begin
            rx_en      <= next_rx_en;
            rx_enable  <= next_rx_enable;
            rx_disable <= next_rx_disable;
            rx_search  <= next_rx_search;
        end
    end

    // transmitter state, flags and pulses
    always_comb begin
        next_tx_en        = tx_en;
        next_tx_enable    = 1'b0;
        next_tx_disable   = 1'b0;
        next_space_flag   = space_flag;
        next_drained_flag = drained_flag;
        if (tx_off) begin
            next_tx_en        = 1'b0;
            next_tx_disable   = 1'b1;
            next_space_flag   = 1'b0;
            next_drained_flag = 1'b0;
        end else if (tx_on) begin
            next_tx_en     = 1'b1;
            next_tx_enable = 1'b1;
            if (i_tx_idle) begin
                next_space_flag   = 1'b1;
                next_drained_flag = 1'b1;
            end
        end else if (tx_en && i_tx_idle) begin
            // flags set while an enabled transmitter is idle
            next_space_flag   = 1'b1;
            next_drained_flag = 1'b1;
        end
        if (misc_dec.tx_reset) begin
            next_tx_en        = cmd_decoder_pkg::TX_EN_RESET;
            next_space_flag   = 1'b0;
            next_drained_flag = 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            tx_en        <= cmd_decoder_pkg::TX_EN_RESET;
            tx_enable    <= 1'b0;
            tx_disable   <= 1'b0;
            space_flag   <= 1'b0;
            drained_flag <= 1'b0;
        end else begin
            tx_en        <= next_tx_en;
            tx_enable    <= next_tx_enable;
            tx_disable   <= next_tx_disable;
            space_flag   <= next_space_flag;
            drained_flag <= next_drained_flag;
        end
    end

    always_comb begin
        if (misc_cmd) begin
            next_gap = cmd_decoder_pkg::MISC_GAP_EDGES;
        end else if (gap != 2'h0) begin
            next_gap = gap - 2'h1;
        end else begin
            next_gap = gap;
        end
    end

    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            gap <= 2'h0;
        end else begin
            gap <= next_gap;
        end
    end

    // misc pulses held for one cycle
    always_ff @(posedge i_mclk or negedge i_nrst) begin
        if (!i_nrst) begin
            misc <= '0;
        end else begin
            misc <= misc_dec;
        end
    end

    assign o_rx_enabled      = rx_en;
    assign o_rx_active       = rx_en || i_multidrop;
    assign o_tx_enabled      = tx_en;
    assign o_tx_running      = tx_en || !i_tx_idle;
    assign o_tx_space_flag   = space_flag;
    assign o_tx_drained_flag = drained_flag;
    assign o_dir             = '{rx_enable:  rx_enable,
                                 rx_disable: rx_disable,
                                 rx_search:  rx_search,
                                 tx_enable:  tx_enable,
                                 tx_disable: tx_disable};
    assign o_misc            = misc;
    // busy while the spacing window is open
    assign o_misc_busy       = gap != 2'h0;
endmodule
